// [rtl/css_pkg.sv]
package css_pkg;

  // Register byte offsets on the APB slave
  localparam logic [11:0] CSS_TRIM_OFFSET = 12'h000;
  localparam logic [11:0] CSS_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] CSS_CONTROL_OFFSET = 12'h008;

  // Reset values
  localparam logic [7:0] CSS_TRIM_RESET = 8'h00;
  localparam logic [3:0] CSS_DIV_BY_ONE = 4'h0;
  localparam logic [3:0] CSS_DIV_BY_EIGHT = 4'h4;

  // Control register field
  localparam int CSS_CTRL_SLEEP_BIT = 0;

  // Status register field positions
  localparam int CSS_ST_RUN_BIT = 0;
  localparam int CSS_ST_TIMEOUT_BIT = 1;
  localparam int CSS_ST_OSCWAIT_BIT = 2;
  localparam int CSS_ST_CAPS_BIT = 3;
  localparam int CSS_ST_DIV_LSB = 4;
  localparam int CSS_ST_SEL_LSB = 8;
  localparam int CSS_ST_SUT_LSB = 12;
  localparam int CSS_ST_DIV8_BIT = 14;

  // Clock source select codes, as read from the fuses
  localparam logic [3:0] CSS_SEL_RC = 4'h2;
  localparam logic [3:0] CSS_SEL_EXTERNAL = 4'h0;
  localparam logic [1:0] CSS_SEL_LOWFREQ_TOP = 2'b01;

  // Start-up time fuse codes
  localparam logic [1:0] CSS_SUT_NONE = 2'b00;
  localparam logic [1:0] CSS_SUT_SHORT = 2'b01;
  localparam logic [1:0] CSS_SUT_LONG = 2'b10;

  // Reset time-outs, nominal times in microseconds
  localparam int CSS_TIMEOUT_SHORT_US = 4100;
  localparam int CSS_TIMEOUT_LONG_US = 65000;
  // Same time-outs as watchdog oscillator cycles
  localparam int CSS_TIMEOUT_SHORT_CYCLES = 4096;
  localparam int CSS_TIMEOUT_LONG_CYCLES = 65536;

  // Wake-up waits in cycles of the selected oscillator
  localparam int CSS_WAKE_FAST_CYCLES = 1024;
  localparam int CSS_WAKE_SLOW_CYCLES = 32768;
  localparam int CSS_WAKE_RC_CYCLES = 6;

  // Fuse bits as read: 1 unprogrammed, 0 programmed
  typedef struct packed {
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_time_fuses;
    logic divide_by_eight_fuse;
  } css_fuse_type;

endpackage

// [rtl/css_clock_startup.sv]
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
// Functional notes
// RULE_01: Select codes 0100-0111 choose watch crystal
// RULE_02: Codes 0110/0111 enable on-chip load capacitors
// RULE_03: Crystal reset delay: none, 4.1ms, 65ms
// RULE_04: Crystal wake: 1K or 32K cycles
// RULE_05: Code 0010 selects internal 8 MHz RC
// RULE_06: Divide-by-eight fuse divides clock from start-up
// RULE_07: Reset copies factory calibration into trim
// RULE_08: Reset time-out counts watchdog oscillator cycles
// RULE_09: RC wake 6 cycles; delay per start-up fuses
// RULE_10: Trim zero slowest, rising to 0x7F fastest
// RULE_11: Software writes trim only 0x00 to 0x7F; code stores any pwdata[7:0] value, 0x80 to 0xFF included
// RULE_12: Keep trim under 10% high during writes
// RULE_13: Code 0000 selects external clock input
// RULE_14: Fuse bit 1 unprogrammed, 0 programmed
// RULE_15: Divider field resets 0100 or 0000
// RULE_16: Clocks gated until time-out and start-up expire
module css_clock_startup #(
  parameter int TIMEOUT_SHORT_CYCLES = css_pkg::CSS_TIMEOUT_SHORT_CYCLES,
  parameter int TIMEOUT_LONG_CYCLES = css_pkg::CSS_TIMEOUT_LONG_CYCLES,
  parameter int WAKE_FAST_CYCLES = css_pkg::CSS_WAKE_FAST_CYCLES,
  parameter int WAKE_SLOW_CYCLES = css_pkg::CSS_WAKE_SLOW_CYCLES,
  parameter int WAKE_RC_CYCLES = css_pkg::CSS_WAKE_RC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire css_pkg::css_fuse_type fuses,
  input wire logic [7:0] factory_calibration,
  input wire logic watchdog_osc_tick,
  input wire logic osc_cycle_tick,
  input wire logic wake_event,
  output logic [7:0] rc_trim_value,
  output logic select_low_freq_crystal,
  output logic select_rc_oscillator,
  output logic select_external_clock,
  output logic load_caps_enable,
  output logic [3:0] system_divider_field,
  output logic clocks_enabled
);
  import css_pkg::*;

  typedef enum logic [2:0] {
    ST_LOAD, ST_TIMEOUT, ST_OSC_WAIT, ST_RUN, ST_SLEEP
  } css_state_type;

  css_state_type state;
  css_state_type next_state;
  css_fuse_type cfg;
  logic [7:0] trim;
  logic [16:0] timeout_count;
  logic [15:0] osc_count;
  logic [16:0] timeout_target;
  logic [15:0] osc_target;
  logic [31:0] status_word;
  logic [31:0] next_prdata;

  // APB decode
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire hit_trim = (paddr == CSS_TRIM_OFFSET);
  wire hit_status = (paddr == CSS_STATUS_OFFSET);
  wire hit_control = (paddr == CSS_CONTROL_OFFSET);
  wire addr_hit = hit_trim | hit_status | hit_control;
  wire write_trim = access_phase & pwrite & hit_trim;
  wire write_sleep = access_phase & pwrite & hit_control &
                     pwdata[CSS_CTRL_SLEEP_BIT];

  assign pready = 1'b1;
  assign pslverr = access_phase & ~addr_hit;

  // Source decode from the latched fuses
  wire [3:0] sel_code = cfg.clock_source_select_fuses;
  wire [1:0] sut_code = cfg.startup_time_fuses;
  wire div8_programmed = ~cfg.divide_by_eight_fuse; // see RULE_14
  wire is_low_freq = (sel_code[3:2] == CSS_SEL_LOWFREQ_TOP); // see RULE_01
  wire is_rc = (sel_code == CSS_SEL_RC); // see RULE_05
  wire is_external = (sel_code == CSS_SEL_EXTERNAL); // see RULE_13

  assign select_low_freq_crystal = is_low_freq; // see RULE_01
  assign select_rc_oscillator = is_rc; // see RULE_05
  assign select_external_clock = is_external; // see RULE_13
  assign load_caps_enable = is_low_freq & sel_code[1]; // see RULE_02
  assign rc_trim_value = trim; // see RULE_10
  assign clocks_enabled = (state == ST_RUN); // see RULE_16

  // Reset time-out in watchdog cycles; reserved code gives none
  always_comb begin
    timeout_target = '0;
    if (is_low_freq | is_rc | is_external) begin
      unique case (sut_code)
        CSS_SUT_SHORT: begin
          timeout_target = 17'(TIMEOUT_SHORT_CYCLES); // see RULE_03
        end
        CSS_SUT_LONG: timeout_target = 17'(TIMEOUT_LONG_CYCLES); // see RULE_09
        default: timeout_target = '0;
      endcase
    end
  end

  // Wake-up wait in cycles of the selected oscillator
  always_comb begin
    osc_target = '0;
    if (is_low_freq) begin
      osc_target = sel_code[0] ? 16'(WAKE_SLOW_CYCLES) :
                                 16'(WAKE_FAST_CYCLES); // see RULE_04
    end else if (is_rc | is_external) begin
      osc_target = 16'(WAKE_RC_CYCLES); // see RULE_09
    end
  end

  wire timeout_done = (timeout_target == '0) |
                      (watchdog_osc_tick &
                       (timeout_count == timeout_target - 17'd1));
  wire osc_done = (osc_target == '0) |
                  (osc_cycle_tick & (osc_count == osc_target - 16'd1));

  // Start-up sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_LOAD: next_state = ST_TIMEOUT;
      ST_TIMEOUT: if (timeout_done) next_state = ST_OSC_WAIT; // see RULE_08
      ST_OSC_WAIT: if (osc_done) next_state = ST_RUN; // see RULE_16
      ST_RUN: if (write_sleep) next_state = ST_SLEEP;
      ST_SLEEP: if (wake_event) next_state = ST_OSC_WAIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  // Reset time-out counter, advanced only by watchdog ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_count <= '0;
    end else if (state != ST_TIMEOUT) begin
      timeout_count <= '0;
    end else if (watchdog_osc_tick) begin
      timeout_count <= timeout_count + 17'd1; // see RULE_08
    end
  end

  // Oscillator start-up counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_count <= '0;
    end else if (state != ST_OSC_WAIT) begin
      osc_count <= '0;
    end else if (osc_cycle_tick) begin
      osc_count <= osc_count + 16'd1;
    end
  end

  // Fuses and divider reset value caught right after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '1;
      system_divider_field <= CSS_DIV_BY_ONE;
    end else if (state == ST_LOAD) begin
      cfg <= fuses;
      system_divider_field <= ~fuses.divide_by_eight_fuse ?
                              CSS_DIV_BY_EIGHT : CSS_DIV_BY_ONE; // see RULE_15
    end
  end

  // Trim register: factory byte after reset, then software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim <= CSS_TRIM_RESET;
    end else if (state == ST_LOAD) begin
      trim <= factory_calibration; // see RULE_07
    end else if (write_trim) begin
      trim <= pwdata[7:0];
    end
  end

  // Status word and read data, captured in the setup phase
  always_comb begin
    status_word = '0;
    status_word[CSS_ST_RUN_BIT] = clocks_enabled;
    status_word[CSS_ST_TIMEOUT_BIT] = (state == ST_TIMEOUT);
    status_word[CSS_ST_OSCWAIT_BIT] = (state == ST_OSC_WAIT);
    status_word[CSS_ST_CAPS_BIT] = load_caps_enable;
    status_word[CSS_ST_DIV_LSB +: 4] = system_divider_field;
    status_word[CSS_ST_SEL_LSB +: 4] = sel_code;
    status_word[CSS_ST_SUT_LSB +: 2] = sut_code;
    status_word[CSS_ST_DIV8_BIT] = div8_programmed; // see RULE_06
  end

  always_comb begin
    next_prdata = '0;
    if (hit_trim) next_prdata = {24'h00_0000, trim};
    else if (hit_status) next_prdata = status_word;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_load_done;
    state == ST_LOAD ##1 state == ST_TIMEOUT;
  endsequence

  sequence seq_timeout_last;
    state == ST_TIMEOUT && timeout_target != '0 && watchdog_osc_tick &&
      timeout_count == timeout_target - 17'd1;
  endsequence

  sequence seq_osc_last;
    state == ST_OSC_WAIT && osc_cycle_tick && osc_target != '0 &&
      osc_count == osc_target - 16'd1;
  endsequence

  AST_LOWFREQ_SEL: assert property ( // see RULE_01
    select_low_freq_crystal == (cfg.clock_source_select_fuses >= 4'h4 &&
                                cfg.clock_source_select_fuses <= 4'h7))
    else $error("low frequency crystal select wrong");
  AST_CAPS: assert property ( // see RULE_02
    load_caps_enable |-> select_low_freq_crystal &&
      cfg.clock_source_select_fuses[1])
    else $error("load capacitors enabled for wrong code");
  AST_CRYSTAL_TIMEOUT: assert property ( // see RULE_03
    state == ST_TIMEOUT && is_low_freq && sut_code == CSS_SUT_NONE
      |=> state == ST_OSC_WAIT)
    else $error("crystal time-out not skipped for code 00");
  AST_CRYSTAL_WAKE: assert property ( // see RULE_04
    is_low_freq |-> osc_target == (sel_code[0] ? 16'd32768 : 16'd1024))
    else $error("crystal wake count wrong");
  AST_RC_SEL: assert property ( // see RULE_05
    select_rc_oscillator |-> !select_low_freq_crystal &&
      !select_external_clock && sel_code == 4'h2)
    else $error("rc select wrong");
  AST_DIV8: assert property ( // see RULE_15
    seq_load_done |-> system_divider_field ==
      ($past(fuses.divide_by_eight_fuse) ? 4'h0 : 4'h4))
    else $error("divider field reset value wrong");
  AST_TRIM_LOAD: assert property ( // see RULE_07
    seq_load_done |-> trim == $past(factory_calibration))
    else $error("calibration byte not loaded");
  AST_TIMEOUT_HOLD: assert property ( // see RULE_08
    state == ST_TIMEOUT && !watchdog_osc_tick && timeout_target != '0
      |=> $stable(timeout_count))
    else $error("time-out advanced without watchdog tick");
  AST_TIMEOUT_END: assert property ( // see RULE_08
    seq_timeout_last |=> state == ST_OSC_WAIT ##1 !clocks_enabled)
    else $error("time-out did not end on last watchdog tick");
  AST_RC_WAKE: assert property ( // see RULE_09
    (is_rc | is_external) |-> osc_target == 16'd6)
    else $error("rc wake count wrong");
  AST_TRIM_WRITE: assert property ( // see RULE_10
    write_trim && state != ST_LOAD |=> rc_trim_value == $past(pwdata[7:0]))
    else $error("trim write not applied");
  AST_EXT_SEL: assert property ( // see RULE_13
    select_external_clock |-> sel_code == 4'h0 && !select_rc_oscillator)
    else $error("external select wrong");
  AST_GATE_RELEASE: assert property ( // see RULE_16
    seq_osc_last |=> clocks_enabled)
    else $error("clocks not released after start-up");
  AST_GATE_HOLD: assert property ( // see RULE_16
    clocks_enabled |-> state == ST_RUN && $past(state) inside
      {ST_RUN, ST_OSC_WAIT})
    else $error("clocks released early");

endmodule // css_clock_startup

// [dv/css_osc_model.sv]
`timescale 1ns/10ps
// Far side: watchdog oscillator and selected source, one pulse per cycle
module css_osc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] period,
  output logic watchdog_osc_tick,
  output logic osc_cycle_tick
);
  logic [3:0] phase;
  // Phase counter sets the spacing of oscillator cycles in pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 4'h0;
    end else begin
      phase <= (phase + 4'h1 >= period) ? 4'h0 : phase + 4'h1;
    end
  end
  // Source edge as seen by the device, crystal or driven clock
  assign osc_cycle_tick = (phase == 4'h0);
  // Watchdog oscillator ticks on the same phase as the system source
  assign watchdog_osc_tick = (phase == 4'h0);
endmodule // css_osc_model

// [dv/clock_source_startup_select_test.sv]
`timescale 1ns/10ps
module clock_source_startup_select_test;
  import css_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wake_event = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, d;
  logic pready, pslverr, last_err, wd_tick, osc_tick;
  css_fuse_type fuses = '{4'h2, 2'b10, 1'b0};
  logic [7:0] factory_calibration = 8'h00, rc_trim_value, fc;
  logic sel_lf, sel_rc, sel_ext, caps, clocks_enabled;
  logic [3:0] system_divider_field, period = 4'h1;
  int error_cnt = 0, n_compared = 0, n, k;
  int sels[9] = '{0, 4, 6, 5, 3, 8, 2, 2, 2};
  int suts[9] = '{1, 2, 0, 1, 0, 3, 1, 2, 0};
  // Clock of 100 ns
  always #50 pclk = ~pclk;
  css_clock_startup #(.TIMEOUT_SHORT_CYCLES(8), .TIMEOUT_LONG_CYCLES(16))
    dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuses(fuses),
    .factory_calibration(factory_calibration),
    .watchdog_osc_tick(wd_tick), .osc_cycle_tick(osc_tick),
    .wake_event(wake_event), .rc_trim_value(rc_trim_value),
    .select_low_freq_crystal(sel_lf), .select_rc_oscillator(sel_rc),
    .select_external_clock(sel_ext), .load_caps_enable(caps),
    .system_divider_field(system_divider_field),
    .clocks_enabled(clocks_enabled));
  css_osc_model osc (.pclk(pclk), .presetn(presetn), .period(period),
    .watchdog_osc_tick(wd_tick), .osc_cycle_tick(osc_tick));
  // Reference start-up length in edges after reset release
  // Ticks land on edges 1, 1+p, 1+2p ... after release
  function automatic int exp_start(int s, int u, int p);
    int t, w, e, f;
    t = (s == 0 || s == 2 || (s >= 4 && s <= 7)) ?
      ((u == 1) ? 8 : (u == 2) ? 16 : 0) : 0;
    w = (s >= 4 && s <= 7) ? ((s % 2) ? 32768 : 1024) : 0;
    if (s == 0 || s == 2) w = 6;
    e = (t < 1) ? 2 : 1 + t * p;
    f = 1;
    while (f <= e) f += p;
    return (w < 1) ? e + 1 : f + (w - 1) * p;
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    d = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts settled samples until the clocks run
  task automatic wait_run();
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (clocks_enabled !== 1'b1 && n < 40000);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    #(100000 * 100);
    error_cnt++;
    summarize();
  end
  initial begin
    void'($urandom(72));
    for (k = 0; k < 9; k++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      period <= (k == 1) ? 4'h2 : 4'h1;
      fc = 8'($urandom);
      factory_calibration <= fc;
      fuses <= '{4'(sels[k]), 2'(suts[k]), 1'($urandom)};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wait_run();
      chk("start", exp_start(sels[k], suts[k], int'(period)),
        n - 1);
      chk("source", {sels[k] >= 4 && sels[k] <= 7, sels[k] == 2,
        sels[k] == 0, sels[k] == 6 || sels[k] == 7},
        {sel_lf, sel_rc, sel_ext, caps});
      chk("div", fuses.divide_by_eight_fuse ? 4'h0 : 4'h4,
        system_divider_field);
      apb(1'b0, CSS_TRIM_OFFSET, 32'h0);
      chk("trim", {24'h0, fc}, d);
      chk("trim err", 32'h0, {31'h0, last_err});
      apb(1'b0, CSS_STATUS_OFFSET, 32'h0);
      chk("status", {17'h0, !fuses.divide_by_eight_fuse, 2'(suts[k]),
        4'(sels[k]), (fuses.divide_by_eight_fuse ? 4'h0 : 4'h4),
        (sels[k] == 6 || sels[k] == 7), 3'b001},
        d);
      $display("test start-up code %0d done", sels[k]);
    end
    fc = 8'($urandom) & 8'h7F;
    apb(1'b1, CSS_TRIM_OFFSET, {24'hABCD_EF, fc});
    apb(1'b0, CSS_TRIM_OFFSET, 32'h0);
    chk("trim rd", {24'h0, fc}, d);
    chk("trim out", {24'h0, fc}, {24'h0, rc_trim_value});
    apb(1'b1, CSS_TRIM_OFFSET, 32'h0000_007F);
    apb(1'b0, CSS_TRIM_OFFSET, 32'h0);
    chk("trim hi", 32'h0000_007F, d);
    chk("trim hi out", 32'h0000_007F, {24'h0, rc_trim_value});
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk("unmapped wr err", 32'h1, {31'h0, last_err});
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped rd", 32'h0, d);
    chk("unmapped rd err", 32'h1, {31'h0, last_err});
    apb(1'b0, CSS_CONTROL_OFFSET, 32'h0);
    chk("control rd", 32'h0, d);
    chk("control rd err", 32'h0, {31'h0, last_err});
    $display("test registers done");
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    repeat (3) @(negedge pclk);
    chk("wake in run", 32'h1, {31'h0, clocks_enabled});
    for (k = 1; k < 4; k += 2) begin
      period <= 4'(k);
      apb(1'b1, CSS_CONTROL_OFFSET, 32'h1);
      @(negedge pclk);
      chk("sleep", 32'h0, {31'h0, clocks_enabled});
      @(posedge pclk);
      wake_event <= 1'b1;
      @(posedge pclk);
      wake_event <= 1'b0;
      wait_run();
      if (k == 1) begin
        chk("wake", CSS_WAKE_RC_CYCLES, n - 1);
      end else begin
        chk("slow wake", 32'h1, {31'h0, n >= 17 && n <= 19});
      end
    end
    $display("test sleep and wake done");
    summarize();
  end
endmodule // clock_source_startup_select_test
